// ==== src/msr_map.svh ====
// memory space router: offsets, bit positions, reset values, default windows
// assumes a 16-bit processor address and an 8-bit data bus
// How it works
// R01: secondary flash select beats an overlapping main flash select.
// R02: sram, control block or, in peripheral io mode, peripheral select beats any flash select.
// R03: configuration keeps same-kind flash sector windows from overlapping.
// R04: configuration keeps sram, control block and peripheral windows disjoint.
// R05: configuration keeps each flash window within its physical sector size.
// R06: example map splits 8000h-BFFFh into sram, secondary, then main flash.
// R07: routing register gates read, write and fetch strobes to each flash, and fetch strobes to sram.
// R08: reset reloads routing register bits 0 to 6 from the nonvolatile value.
// R09: processor writes to the routing register take effect on later cycles.
// R10: bits 4,3 pass data to main,secondary; bits 2,1 pass fetch.
// R11: bit 0 adds fetch to sram; data always reaches sram.
// R12: control block answers data cycles only, never fetches.
// R13: bit 7 enables peripheral io mode, cleared on reset; bits 6,5 unused.
// R14: routing register sits at control block base plus E2h.
// R15: bit 7 acts independently of memory routing bits 0 to 4.
// R16: no hit, or a gated-off hit, enables no memory.
// R17: reading the routing register returns the value in force.
`ifndef MSR_MAP_SVH
`define MSR_MAP_SVH

// ----------------------------------------
// register placement and fields
// ----------------------------------------
`define MSR_ROUTING_OFS     8'hE2
`define MSR_PERIPH_BIT      7
`define MSR_MAIN_DATA_BIT   4
`define MSR_BOOT_DATA_BIT   3
`define MSR_MAIN_FETCH_BIT  2
`define MSR_BOOT_FETCH_BIT  1
`define MSR_SRAM_FETCH_BIT  0
`define MSR_PERIPH_RESET    1'b0
`define MSR_RDATA_RESET     8'h00

// ----------------------------------------
// default decode windows
// ----------------------------------------
`define MSR_MAIN_LO_DFLT    {{7{16'h0000}}, 16'h8000}
`define MSR_MAIN_HI_DFLT    {{7{16'h0000}}, 16'hBFFF}
`define MSR_MAIN_USED_DFLT  8'h01
`define MSR_BOOT_LO_DFLT    {{3{16'h0000}}, 16'h8000}
`define MSR_BOOT_HI_DFLT    {{3{16'h0000}}, 16'h9FFF}
`define MSR_BOOT_USED_DFLT  4'h1
`define MSR_SRAM_LO_DFLT    16'h8000
`define MSR_SRAM_HI_DFLT    16'h87FF
`define MSR_CTRL_BASE_DFLT  16'h0200
`define MSR_PERIPH_LO_DFLT  16'h0300
`define MSR_PERIPH_HI_DFLT  16'h03FF

`endif

// ==== src/msr_pkg.sv ====
// memory space router: shared types
// assumes msr_map.svh supplies the numbers
package msr_pkg;

    typedef logic [15:0] msr_addr_t;
    typedef logic [7:0]  msr_byte_t;

    typedef struct packed {
        msr_byte_t routing;
        msr_byte_t rdata;
    } msr_state_t;

endpackage

// ==== src/msr_sel_decode.sv ====
// memory space router: address window decode for every select
// assumes windows come from configuration and are held constant
`timescale 1ns/10ps
`include "msr_map.svh"

module msr_sel_decode #(
    parameter logic [127:0] MAIN_LO   = `MSR_MAIN_LO_DFLT,
    parameter logic [127:0] MAIN_HI   = `MSR_MAIN_HI_DFLT,
    parameter logic [7:0]   MAIN_USED = `MSR_MAIN_USED_DFLT,
    parameter logic [63:0]  BOOT_LO   = `MSR_BOOT_LO_DFLT,
    parameter logic [63:0]  BOOT_HI   = `MSR_BOOT_HI_DFLT,
    parameter logic [3:0]   BOOT_USED = `MSR_BOOT_USED_DFLT,
    parameter logic [15:0]  SRAM_LO   = `MSR_SRAM_LO_DFLT,
    parameter logic [15:0]  SRAM_HI   = `MSR_SRAM_HI_DFLT,
    parameter logic [15:0]  CTRL_BASE = `MSR_CTRL_BASE_DFLT,
    parameter logic [15:0]  PERIPH_LO = `MSR_PERIPH_LO_DFLT,
    parameter logic [15:0]  PERIPH_HI = `MSR_PERIPH_HI_DFLT
) (
    input  wire msr_pkg::msr_addr_t addr,
    output logic [7:0]              main_hit,
    output logic [3:0]              boot_hit,
    output logic                    sram_hit,
    output logic                    ctrl_hit,
    output logic                    reg_hit,
    output logic                    periph_hit
);

    function automatic logic in_win(input logic [15:0] a,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
        in_win = (a >= lo) && (a <= hi);
    endfunction

    // ----------------------------------------
    // flash sector windows
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_main
            assign main_hit[gi] = MAIN_USED[gi] &&
                in_win(addr, MAIN_LO[gi*16 +: 16], MAIN_HI[gi*16 +: 16]);
        end
        for (gi = 0; gi < 4; gi++) begin : g_boot
            assign boot_hit[gi] = BOOT_USED[gi] &&
                in_win(addr, BOOT_LO[gi*16 +: 16], BOOT_HI[gi*16 +: 16]);
        end
    endgenerate

    // ----------------------------------------
    // top level windows
    // ----------------------------------------
    assign sram_hit   = in_win(addr, SRAM_LO, SRAM_HI);
    assign ctrl_hit   = (addr[15:8] == CTRL_BASE[15:8]);
    // control block is one 256-byte page on a page boundary
    assign reg_hit    = ctrl_hit && (addr[7:0] == `MSR_ROUTING_OFS); // R14
    assign periph_hit = in_win(addr, PERIPH_LO, PERIPH_HI);

endmodule

// ==== src/msr_priority.sv ====
// memory space router: priority resolution and strobe gating
// assumes at most one of data and fetch strobes is active at once
`timescale 1ns/10ps
`include "msr_map.svh"

module msr_priority (
    input  wire logic [7:0] main_hit,
    input  wire logic [3:0] boot_hit,
    input  wire logic       sram_hit,
    input  wire logic       ctrl_hit,
    input  wire logic       periph_hit,
    input  wire logic       data_cyc,
    input  wire logic       fetch_cyc,
    input  wire logic [7:0] routing,
    output logic [7:0]      main_flash_en,
    output logic [3:0]      boot_flash_en,
    output logic            sram_en,
    output logic            ctrl_block_en,
    output logic            periph_sel_en
);

    logic top_claim;
    logic boot_claim;
    logic main_ok;
    logic boot_ok;

    function automatic logic pass(input logic data_bit,
                                  input logic fetch_bit,
                                  input logic dcyc,
                                  input logic fcyc);
        pass = (dcyc && data_bit) || (fcyc && fetch_bit);
    endfunction

    // peripheral window only claims the bus in peripheral io mode
    assign top_claim  = sram_hit || ctrl_hit || (periph_hit && routing[`MSR_PERIPH_BIT]); // R02
    assign boot_claim = |boot_hit;

    assign main_ok = pass(routing[`MSR_MAIN_DATA_BIT], routing[`MSR_MAIN_FETCH_BIT],
                          data_cyc, fetch_cyc); // R10
    assign boot_ok = pass(routing[`MSR_BOOT_DATA_BIT], routing[`MSR_BOOT_FETCH_BIT],
                          data_cyc, fetch_cyc); // R10

    // a gated-off winner does not fall through to a lower memory
    always_comb begin
        sram_en       = sram_hit && pass(1'b1, routing[`MSR_SRAM_FETCH_BIT],
                                         data_cyc, fetch_cyc); // R11
        ctrl_block_en = ctrl_hit && data_cyc; // R12
        periph_sel_en = periph_hit && routing[`MSR_PERIPH_BIT] && data_cyc; // R15
        boot_flash_en = (top_claim || !boot_ok) ? 4'h0 : boot_hit; // R01 R07
        main_flash_en = (top_claim || boot_claim || !main_ok) ? 8'h00 : main_hit; // R16
    end

endmodule

// ==== src/msr_router.sv ====
// memory space router: top level, routing register and bus read-back
// assumes active-low processor strobes, synchronous to mclk, one at a time
// assumes a read strobe is held at least two mclk cycles
`timescale 1ns/10ps
`include "msr_map.svh"

module msr_router #(
    parameter logic [127:0] MAIN_LO   = `MSR_MAIN_LO_DFLT,
    parameter logic [127:0] MAIN_HI   = `MSR_MAIN_HI_DFLT,
    parameter logic [7:0]   MAIN_USED = `MSR_MAIN_USED_DFLT,
    parameter logic [63:0]  BOOT_LO   = `MSR_BOOT_LO_DFLT,
    parameter logic [63:0]  BOOT_HI   = `MSR_BOOT_HI_DFLT,
    parameter logic [3:0]   BOOT_USED = `MSR_BOOT_USED_DFLT,
    parameter logic [15:0]  SRAM_LO   = `MSR_SRAM_LO_DFLT,
    parameter logic [15:0]  SRAM_HI   = `MSR_SRAM_HI_DFLT,
    parameter logic [15:0]  CTRL_BASE = `MSR_CTRL_BASE_DFLT,
    parameter logic [15:0]  PERIPH_LO = `MSR_PERIPH_LO_DFLT,
    parameter logic [15:0]  PERIPH_HI = `MSR_PERIPH_HI_DFLT
) (
    input  wire logic               mclk,
    input  wire logic               srst,
    input  wire msr_pkg::msr_addr_t bus_addr,
    input  wire logic               bus_rd_n,
    input  wire logic               bus_wr_n,
    input  wire logic               bus_psen_n,
    input  wire msr_pkg::msr_byte_t bus_wdata,
    input  wire msr_pkg::msr_byte_t nv_routing_value,
    output msr_pkg::msr_byte_t      bus_rdata,
    output logic                    bus_rdata_en,
    output logic [7:0]              main_flash_en,
    output logic [3:0]              boot_flash_en,
    output logic                    sram_en,
    output logic                    ctrl_block_en,
    output logic                    periph_sel_en,
    output logic                    periph_io_enable
);

    // ----------------------------------------
    // state and decode wires
    // ----------------------------------------
    msr_pkg::msr_state_t st;
    msr_pkg::msr_state_t next_st;

    logic [7:0] main_hit;
    logic [3:0] boot_hit;
    logic       sram_hit;
    logic       ctrl_hit;
    logic       reg_hit;
    logic       periph_hit;
    logic       data_cyc;
    logic       fetch_cyc;
    logic       rd_cyc;
    logic       wr_cyc;
    logic       reg_wr;
    logic       reg_rd;
    logic       ctrl_rd;

    assign rd_cyc    = !bus_rd_n;
    assign wr_cyc    = !bus_wr_n;
    assign data_cyc  = rd_cyc || wr_cyc;
    assign fetch_cyc = !bus_psen_n;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    msr_sel_decode #(
        .MAIN_LO   (MAIN_LO),
        .MAIN_HI   (MAIN_HI),
        .MAIN_USED (MAIN_USED),
        .BOOT_LO   (BOOT_LO),
        .BOOT_HI   (BOOT_HI),
        .BOOT_USED (BOOT_USED),
        .SRAM_LO   (SRAM_LO),
        .SRAM_HI   (SRAM_HI),
        .CTRL_BASE (CTRL_BASE),
        .PERIPH_LO (PERIPH_LO),
        .PERIPH_HI (PERIPH_HI)
    ) u_decode (
        .addr       (bus_addr),
        .main_hit   (main_hit),
        .boot_hit   (boot_hit),
        .sram_hit   (sram_hit),
        .ctrl_hit   (ctrl_hit),
        .reg_hit    (reg_hit),
        .periph_hit (periph_hit)
    );

    // ----------------------------------------
    // priority and strobe routing
    // ----------------------------------------
    msr_priority u_prio (
        .main_hit      (main_hit),
        .boot_hit      (boot_hit),
        .sram_hit      (sram_hit),
        .ctrl_hit      (ctrl_hit),
        .periph_hit    (periph_hit),
        .data_cyc      (data_cyc),
        .fetch_cyc     (fetch_cyc),
        .routing       (st.routing),
        .main_flash_en (main_flash_en),
        .boot_flash_en (boot_flash_en),
        .sram_en       (sram_en),
        .ctrl_block_en (ctrl_block_en),
        .periph_sel_en (periph_sel_en)
    );

    // ----------------------------------------
    // routing register and read-back
    // ----------------------------------------
    // register access rides on the data-only control block enable
    assign reg_wr  = ctrl_block_en && reg_hit && wr_cyc; // R09
    assign reg_rd  = ctrl_block_en && reg_hit && rd_cyc; // R14
    assign ctrl_rd = ctrl_block_en && rd_cyc;

    always_comb begin
        next_st = st;
        if (srst) begin
            // runtime value is dropped; peripheral mode always comes up off
            next_st.routing = {`MSR_PERIPH_RESET, nv_routing_value[6:0]}; // R08 R13
            next_st.rdata   = `MSR_RDATA_RESET;
        end else begin
            if (reg_wr) begin
                next_st.routing = bus_wdata; // R09
            end
            if (reg_rd) begin
                next_st.rdata = st.routing; // R17
            end else if (ctrl_rd) begin
                // other control-block registers live elsewhere
                next_st.rdata = `MSR_RDATA_RESET;
            end
        end
    end

    always_ff @(posedge mclk) begin
        st <= next_st;
    end

    assign bus_rdata        = st.rdata;
    assign bus_rdata_en     = ctrl_rd;
    assign periph_io_enable = st.routing[`MSR_PERIPH_BIT]; // R13 R15

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    logic [6:0] nv_low;
    logic       any_hit;
    logic [14:0] all_en;

    assign nv_low  = nv_routing_value[6:0];
    assign any_hit = (|main_hit) || (|boot_hit) || sram_hit || ctrl_hit || periph_hit;
    assign all_en  = {main_flash_en, boot_flash_en, sram_en, ctrl_block_en, periph_sel_en};

    sequence reg_write_s;
        reg_wr ##1 !reg_wr;
    endsequence

    sequence reg_read_s;
        reg_rd && !reg_wr;
    endsequence

    boot_wins_a:  // R01
    assert property ((|boot_hit) && (|main_hit) |-> main_flash_en == 8'h00)
        else $error("main flash enabled under a secondary flash hit");

    top_wins_a:  // R02
    assert property ((sram_hit || ctrl_hit) |->
                     (main_flash_en == 8'h00) && (boot_flash_en == 4'h0))
        else $error("flash enabled under a top level hit");

    example_split_a:  // R06
    assert property ((|boot_hit) && !sram_hit && !ctrl_hit && !periph_hit &&
                     data_cyc && st.routing[`MSR_BOOT_DATA_BIT] |->
                     (boot_flash_en == boot_hit) && (main_flash_en == 8'h00))
        else $error("secondary flash window not served by secondary flash");

    main_gate_a:  // R07
    assert property ((|main_flash_en) |->
                     (data_cyc && st.routing[`MSR_MAIN_DATA_BIT]) ||
                     (fetch_cyc && st.routing[`MSR_MAIN_FETCH_BIT]))
        else $error("main flash enabled by a gated strobe");

    boot_fetch_a:  // R10
    assert property (fetch_cyc && !data_cyc && (|boot_flash_en) |->
                     st.routing[`MSR_BOOT_FETCH_BIT])
        else $error("fetch reached secondary flash while blocked");

    reset_load_a:  // R08
    assert property ($fell(srst) |->
                     st.routing == {`MSR_PERIPH_RESET, $past(nv_low)})
        else $error("routing not reloaded from nonvolatile value");

    write_takes_a:  // R09
    assert property (reg_write_s |-> st.routing == $past(bus_wdata, 1))
        else $error("routing write did not take effect");

    sram_data_a:  // R11
    assert property (sram_hit && data_cyc |-> sram_en)
        else $error("data cycle did not reach sram");

    ctrl_fetch_a:  // R12
    assert property (fetch_cyc && !data_cyc |-> !ctrl_block_en)
        else $error("control block answered a fetch");

    periph_bit_a:  // R15
    assert property (periph_hit && data_cyc |->
                     periph_sel_en == st.routing[`MSR_PERIPH_BIT])
        else $error("peripheral window not governed by bit 7 alone");

    no_hit_a:  // R16
    assert property (!any_hit |-> all_en == 15'h0000)
        else $error("memory enabled with no window hit");

    read_back_a:  // R17
    assert property (reg_read_s |=> bus_rdata == $past(st.routing))
        else $error("routing read-back mismatch");

    // ----------------------------------------
    // strobe gating per memory
    // ----------------------------------------
    // a flash hit only counts when nothing on the top level claims the cycle
    logic top_any;

    assign top_any = sram_hit || ctrl_hit || (periph_hit && st.routing[`MSR_PERIPH_BIT]);

    sequence data_only_s;
        data_cyc && !fetch_cyc;
    endsequence

    sequence fetch_only_s;
        fetch_cyc && !data_cyc;
    endsequence

    periph_wins_a:  // R02
    assert property (periph_hit && st.routing[`MSR_PERIPH_BIT] |->
                     (main_flash_en == 8'h00) && (boot_flash_en == 4'h0))
        else $error("flash enabled under a peripheral window hit");

    main_data_gate_a:  // R10
    assert property (data_only_s ##0 ((|main_hit) && !(|boot_hit) && !top_any) |->
                     (main_flash_en == main_hit) == st.routing[`MSR_MAIN_DATA_BIT])
        else $error("data access to main flash not gated by its bit");

    main_fetch_gate_a:  // R10
    assert property (fetch_only_s ##0 ((|main_hit) && !(|boot_hit) && !top_any) |->
                     (main_flash_en == main_hit) == st.routing[`MSR_MAIN_FETCH_BIT])
        else $error("fetch from main flash not gated by its bit");

    boot_data_block_a:  // R16
    assert property (data_only_s ##0 ((|boot_hit) && !top_any &&
                     !st.routing[`MSR_BOOT_DATA_BIT]) |-> all_en == 15'h0000)
        else $error("blocked secondary flash data cycle fell through");

    boot_fetch_pass_a:  // R10
    assert property (fetch_only_s ##0 ((|boot_hit) && !top_any &&
                     st.routing[`MSR_BOOT_FETCH_BIT]) |-> boot_flash_en == boot_hit)
        else $error("enabled fetch did not reach secondary flash");

    sram_fetch_a:  // R11
    assert property (fetch_only_s ##0 sram_hit |->
                     sram_en == st.routing[`MSR_SRAM_FETCH_BIT])
        else $error("sram fetch not gated by its bit");

    sram_block_a:  // R16
    assert property (fetch_only_s ##0 (sram_hit && !st.routing[`MSR_SRAM_FETCH_BIT]) |->
                     all_en == 15'h0000)
        else $error("blocked sram fetch fell through");

    // ----------------------------------------
    // control block and register checks
    // ----------------------------------------
    ctrl_data_a:  // R12
    assert property (ctrl_hit && data_cyc |-> ctrl_block_en)
        else $error("data cycle did not reach the control block");

    fetch_no_periph_a:  // R13
    assert property (fetch_only_s |-> !periph_sel_en)
        else $error("peripheral window answered a fetch");

    periph_reset_a:  // R13
    assert property ($fell(srst) |-> !periph_io_enable)
        else $error("peripheral mode survived reset");

    unused_bits_a:  // R13
    assert property (reg_write_s |-> st.routing[6:5] == $past(bus_wdata[6:5]))
        else $error("unused routing bits not stored");

    routing_hold_a:  // R09
    assert property (!reg_wr |=> $stable(st.routing))
        else $error("routing changed without a write");

    rdata_hold_a:  // R17
    assert property (!ctrl_rd |=> $stable(bus_rdata))
        else $error("read data changed without a read");

    other_offset_a:  // R14
    assert property (ctrl_rd && !reg_hit |=> bus_rdata == `MSR_RDATA_RESET)
        else $error("other control offset did not read zero");

    rdata_en_a:  // R14
    assert property (bus_rdata_en |-> ctrl_hit && rd_cyc && !fetch_cyc)
        else $error("read drive enabled outside a control block read");

endmodule

// ==== verif/msr_cpu_model.sv ====
// processor bus partner: one read, write or fetch cycle at a time
// assumes a single bench process calls issue, then finish_cyc
`timescale 1ns/10ps
module msr_cpu_model (
    input  wire logic               mclk,
    output msr_pkg::msr_addr_t      bus_addr,
    output logic                    bus_rd_n,
    output logic                    bus_wr_n,
    output logic                    bus_psen_n,
    output msr_pkg::msr_byte_t      bus_wdata
);
    initial begin
        bus_addr   = 16'h0000;
        bus_wdata  = 8'h00;
        bus_rd_n   = 1'b1;
        bus_wr_n   = 1'b1;
        bus_psen_n = 1'b1;
    end

    // ----------------------------------------
    // bus cycles
    // ----------------------------------------
    // kind 0 data read, 1 data write, 2 program fetch; never two strobes at once
    task automatic issue(input int k, input msr_pkg::msr_addr_t a,
                         input msr_pkg::msr_byte_t d);
        @(posedge mclk);
        #1;
        bus_addr   = a;
        bus_wdata  = d;
        bus_rd_n   = (k != 0);
        bus_wr_n   = (k != 1);
        bus_psen_n = (k != 2);
    endtask

    // strobe held two edges; stale values are inverted so nothing leans on them
    task automatic finish_cyc;
        repeat (2) @(posedge mclk);
        #1;
        bus_rd_n   = 1'b1;
        bus_wr_n   = 1'b1;
        bus_psen_n = 1'b1;
        bus_addr   = ~bus_addr;
        bus_wdata  = ~bus_wdata;
    endtask
endmodule

// ==== verif/test_memory_space_router.sv ====
// router bench: register access and decode checks through the bus partner
// assumes default decode windows: main 8000-BFFF, boot 8000-9FFF, sram 8000-87FF
`timescale 1ns/10ps
module test_memory_space_router;
    logic               mclk = 1'b0;
    logic               srst = 1'b1;
    msr_pkg::msr_byte_t nv_routing_value = 8'h00;
    msr_pkg::msr_addr_t bus_addr;
    logic               bus_rd_n, bus_wr_n, bus_psen_n, bus_rdata_en;
    msr_pkg::msr_byte_t bus_wdata, bus_rdata;
    logic [7:0]         main_flash_en;
    logic [3:0]         boot_flash_en;
    logic               sram_en, ctrl_block_en, periph_sel_en, periph_io_enable;
    int                 errors = 0;
    int                 checked = 0;

    always #10 mclk = ~mclk;

    msr_cpu_model u_msr_cpu_model (.mclk(mclk), .bus_addr(bus_addr), .bus_rd_n(bus_rd_n),
        .bus_wr_n(bus_wr_n), .bus_psen_n(bus_psen_n), .bus_wdata(bus_wdata));

    // default windows never overlap same-level selects and fit their sectors
    msr_router u_msr_router (.mclk(mclk), .srst(srst), .bus_addr(bus_addr),
        .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n), .bus_psen_n(bus_psen_n),
        .bus_wdata(bus_wdata), .nv_routing_value(nv_routing_value),
        .bus_rdata(bus_rdata), .bus_rdata_en(bus_rdata_en),
        .main_flash_en(main_flash_en), .boot_flash_en(boot_flash_en),
        .sram_en(sram_en), .ctrl_block_en(ctrl_block_en),
        .periph_sel_en(periph_sel_en), .periph_io_enable(periph_io_enable));

    // ----------------------------------------
    // compares and verdict
    // ----------------------------------------
    task automatic flag(input string m);
        errors++;
        $display("unexpected at %0t: %s", $time, m);
    endtask

    // e = {main0, boot0, sram, ctrl, periph}
    task automatic cmp_en(input logic [4:0] e);
        checked++;
        if ({main_flash_en, boot_flash_en, sram_en, ctrl_block_en, periph_sel_en}
            !== {7'h00, e[4], 3'h0, e[3], e[2:0]})
            flag($sformatf("enables at %h", bus_addr));
    endtask

    task automatic cmp_byte(input msr_pkg::msr_byte_t g, input msr_pkg::msr_byte_t e);
        checked++;
        if (g !== e)
            flag($sformatf("read %h, wanted %h", g, e));
    endtask

    task automatic cmp_bit(input logic g, input logic e);
        checked++;
        if (g !== e)
            flag("flag level");
    endtask

    task automatic wrap_up;
        $display("errors %0d, checked %0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic rst_dut(input msr_pkg::msr_byte_t nv);
        @(posedge mclk);
        #1;
        nv_routing_value = nv;
        srst = 1'b1;
        repeat (16) @(posedge mclk);
        #1;
        srst = 1'b0;
    endtask

    task automatic cyc(input int k, input msr_pkg::msr_addr_t a, input logic [4:0] e);
        u_msr_cpu_model.issue(k, a, 8'h00);
        #2;
        cmp_en(e);
        cmp_bit(bus_rdata_en, (k == 0) && e[1]);
        u_msr_cpu_model.finish_cyc();
    endtask

    task automatic wr_reg(input msr_pkg::msr_byte_t d);
        u_msr_cpu_model.issue(1, 16'h02E2, d);
        u_msr_cpu_model.finish_cyc();
    endtask

    // data lands one edge after the strobe is seen
    task automatic rd_reg(input msr_pkg::msr_addr_t a, input msr_pkg::msr_byte_t e);
        u_msr_cpu_model.issue(0, a, 8'h00);
        #2;
        cmp_bit(bus_rdata_en, 1'b1);
        @(posedge mclk);
        #2;
        cmp_byte(bus_rdata, e);
        u_msr_cpu_model.finish_cyc();
    endtask

    initial begin
        #60000;
        errors++;
        wrap_up();
    end

    initial begin
        rst_dut(8'h8C);
        cmp_bit(periph_io_enable, 1'b0);
        rd_reg(16'h02E2, 8'h0C);
        cyc(0, 16'h8100, 5'b00100);
        cyc(1, 16'h9000, 5'b01000);
        cyc(0, 16'hA000, 5'b00000);
        cyc(2, 16'hA000, 5'b10000);
        cyc(2, 16'h9000, 5'b00000);
        cyc(2, 16'h8100, 5'b00000);
        cyc(0, 16'h4000, 5'b00000);
        cyc(0, 16'h0300, 5'b00000);
        wr_reg(8'h1F);
        rd_reg(16'h02E2, 8'h1F);
        cyc(1, 16'hA000, 5'b10000);
        cyc(2, 16'h8100, 5'b00100);
        cyc(2, 16'h9000, 5'b01000);
        wr_reg(8'hE0);
        cmp_bit(periph_io_enable, 1'b1);
        cyc(0, 16'h0300, 5'b00001);
        cyc(2, 16'h0300, 5'b00000);
        cyc(1, 16'h8100, 5'b00100);
        cyc(0, 16'h9000, 5'b00000);
        cyc(2, 16'h02E2, 5'b00000);
        cyc(0, 16'h0210, 5'b00010);
        rd_reg(16'h0210, 8'h00);
        rd_reg(16'h02E2, 8'hE0);
        rst_dut(8'h7F);
        rd_reg(16'h02E2, 8'h7F);
        cmp_bit(periph_io_enable, 1'b0);
        wrap_up();
    end
endmodule
